/* File: sysctl_gate_pkg.sv */
package sysctl_gate_pkg;

	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;

	// Byte offsets of the registers.
	localparam logic [9:0] OFS_CAP_PINS   = 10'h018;
	localparam logic [9:0] OFS_CAP_GPIO   = 10'h01c;
	localparam logic [9:0] OFS_RUN_GATE   = 10'h100;
	localparam logic [9:0] OFS_SLEEP_GATE = 10'h110;
	localparam logic [9:0] OFS_DEEP_GATE  = 10'h120;
	localparam logic [9:0] OFS_RUN_CFG    = 10'h060;
	localparam logic [9:0] OFS_PWR_STATE  = 10'h1f0;

	// Capability word layouts.
	localparam int unsigned CAP_SLOW_CLK_BIT = 31;
	localparam int unsigned CAP_TIMER_LSB    = 24;
	localparam int unsigned CAP_TIMER_W      = 6;
	localparam int unsigned CAP_CMP_LSB      = 6;
	localparam int unsigned CAP_CMP_W        = 9;
	localparam int unsigned CAP_PORT_LSB     = 0;
	localparam int unsigned CAP_PORT_W       = 5;

	// Gating register layout: only the watchdog bit exists.
	localparam int unsigned WDOG_BIT       = 3;
	localparam logic [31:0] GATE_WR_MASK   = 32'h0000_0008;
	localparam logic [31:0] GATE_RESET     = 32'h0000_0000;

	// Run configuration: automatic gating select.
	localparam int unsigned AUTO_GATE_BIT  = 27;
	localparam logic [31:0] RUN_CFG_MASK   = 32'h0800_0000;
	localparam logic [31:0] RUN_CFG_RESET  = 32'h0000_0000;

	localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

	// Power states, one-hot.
	typedef enum logic [2:0] {
		PWR_RUN   = 3'h1,
		PWR_SLEEP = 3'h2,
		PWR_DEEP  = 3'h4
	} pwr_state_t;

endpackage

/* File: gate_select.sv */
`timescale 1ns/1ps
// Picks the gating set that applies in the present power state.
module gate_select
	import sysctl_gate_pkg::*;
#(
	parameter int unsigned WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] run_set_in,   // Run-mode set
	input  wire logic [WIDTH-1:0] sleep_set_in, // Sleep-mode set
	input  wire logic [WIDTH-1:0] deep_set_in,  // Deep-sleep set
	input  wire logic             auto_in,      // Automatic gating select
	input  wire logic             sleep_in,     // In sleep
	input  wire logic             deep_in,      // In deep sleep
	output logic      [WIDTH-1:0] set_out       // Set in force
);
	always_comb begin
		set_out = run_set_in;
		if (auto_in && deep_in) begin
			set_out = deep_set_in;
		end else if (auto_in && sleep_in) begin
			set_out = sleep_set_in;
		end
	end
endmodule // gate_select

/* File: capability_and_clock_gating_regs.sv */
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - each writable gating bit enables the clock of exactly one unit.
// - bit one clocks the unit; bit zero leaves it unclocked and disabled.
// - access to a unit whose clock is gated off returns a bus fault.
// - all gating bits reset to zero unless stated otherwise.
// - run, sleep and deep-sleep sets, applied per current power state.
// - sleep sets apply only with automatic gating select set.
// - bit 3 of each gating register is read/write watchdog gate.
// - gating positions without a unit are read-only zero.
// - pins word bits 14..6 report comparator pins, all one.
// - gpio word bits 4..0 report ports A..E, upper bits zero.
// - port flags align with third gating set and soft reset bits.
module capability_and_clock_gating_regs
	import sysctl_gate_pkg::*;
#(
	parameter logic [5:0] TIMER_PINS  = 6'h3f,
	parameter logic [8:0] CMP_PINS    = 9'h1ff,
	parameter logic [4:0] GPIO_PORTS  = 5'h1f,
	parameter logic       SLOW_CLK_IN = 1'b1
) (
	input  wire logic                                ref_clk_in,     // Clock
	input  wire logic                                rst_n_in,       // Reset
	input  wire logic [sysctl_gate_pkg::ADDR_W-1:0]  address_in,     // Byte addr
	input  wire logic                                read_in,        // Read
	input  wire logic                                write_in,       // Write
	input  wire logic [3:0]                          byteenable_in,  // Lanes
	input  wire logic [sysctl_gate_pkg::DATA_W-1:0]  writedata_in,   // Wr data
	output logic      [sysctl_gate_pkg::DATA_W-1:0]  readdata_out,   // Rd data
	output logic                                     waitrequest_out,// Stall
	output logic      [1:0]                          response_out,   // 0 ok
	input  wire logic                                sleep_in,       // Sleep
	input  wire logic                                deep_sleep_in,  // Deep
	input  wire logic                                wdog_access_in, // Wdog acc
	output logic                                     wdog_fault_out, // Fault
	output logic                                     wdog_clk_en_out // Wdog en
);
	import sysctl_gate_pkg::*;

	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	logic [31:0] run_gate_set;
	logic [31:0] sleep_gate_set;
	logic [31:0] deep_sleep_gate_set;
	logic [31:0] run_clock_configuration;
	logic [31:0] capability_pins_word;
	logic [31:0] capability_gpio_word;
	logic [31:0] gate_in_force;
	logic [31:0] wmask;
	logic [31:0] next_readdata;
	logic [1:0]  next_response;
	logic        done;
	logic        access;
	pwr_state_t  pwr_state;

	// The answer takes one wait cycle so read data come from a flop.
	assign access          = read_in | write_in;
	assign waitrequest_out = access & ~done;

	// Constant words; no write path reaches them.
	always_comb begin
		capability_pins_word = 32'h0000_0000;
		capability_pins_word[CAP_SLOW_CLK_BIT] = SLOW_CLK_IN;
		capability_pins_word[CAP_TIMER_LSB +: CAP_TIMER_W] =
			TIMER_PINS;
		capability_pins_word[CAP_CMP_LSB +: CAP_CMP_W] =
			CMP_PINS;
		capability_gpio_word = 32'h0000_0000;
		capability_gpio_word[CAP_PORT_LSB +: CAP_PORT_W] =
			GPIO_PORTS;
	end

	// Byte lanes become a bit mask so a partial write keeps the other lanes.
	always_comb begin
		wmask = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
			{8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
	end

	// A stored bit takes the new value only where its lane is enabled and
	// the bit is writable; positions with no unit never store anything.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] lanes,
		input logic [31:0] legal);
		merge = ((old & ~lanes) | (wd & lanes)) & legal;
	endfunction

	// Only writable bits are stored; all others read zero.
	// A write is taken once, at the edge that ends its first cycle.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			run_gate_set        <= GATE_RESET;
			sleep_gate_set      <= GATE_RESET;
			deep_sleep_gate_set <= GATE_RESET;
		end else if (write_in && !done) begin
			if (address_in == OFS_RUN_GATE) begin
				run_gate_set <= merge(run_gate_set, writedata_in, wmask,
					GATE_WR_MASK);
			end
			if (address_in == OFS_SLEEP_GATE) begin
				sleep_gate_set <= merge(sleep_gate_set, writedata_in,
					wmask, GATE_WR_MASK);
			end
			if (address_in == OFS_DEEP_GATE) begin
				deep_sleep_gate_set <= merge(deep_sleep_gate_set,
					writedata_in, wmask, GATE_WR_MASK);
			end
		end
	end

	// Only the automatic gating select is stored here; the rest of the word
	// reads zero, so a read-modify-write by software cannot set stray bits.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			run_clock_configuration <= RUN_CFG_RESET;
		end else if (write_in && !done && address_in == OFS_RUN_CFG) begin
			run_clock_configuration <= merge(run_clock_configuration,
				writedata_in, wmask, RUN_CFG_MASK);
		end
	end

	// Deep sleep wins when both requests are up, being the lower power state.
	// Registering the state gives one decision point per cycle.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			pwr_state <= PWR_RUN;
		end else if (deep_sleep_in) begin
			pwr_state <= PWR_DEEP;
		end else if (sleep_in) begin
			pwr_state <= PWR_SLEEP;
		end else begin
			pwr_state <= PWR_RUN;
		end
	end

	// A change of power state or of the select bit moves the enable one
	// cycle after the request, once the state register has caught it.
	gate_select #(
		.WIDTH(32)
	) u_select (
		.run_set_in   (run_gate_set),
		.sleep_set_in (sleep_gate_set),
		.deep_set_in  (deep_sleep_gate_set),
		.auto_in      (run_clock_configuration[AUTO_GATE_BIT]),
		.sleep_in     (pwr_state == PWR_SLEEP),
		.deep_in      (pwr_state == PWR_DEEP),
		.set_out      (gate_in_force)
	);

	// The enable is a mux of flops and may glitch while the set in force
	// changes; a clock gate fed by it must latch it while the clock is low.
	assign wdog_clk_en_out = gate_in_force[WDOG_BIT];

	// A unit access while its clock is off is answered with a fault.
	// The pulse lasts one cycle for each cycle that the access is held.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			wdog_fault_out <= 1'b0;
		end else begin
			wdog_fault_out <= wdog_access_in &
				~gate_in_force[WDOG_BIT];
		end
	end

	// Unmapped offsets answer with an error and zero data; writes to them
	// change nothing.
	always_comb begin
		next_response = RESP_OK;
		next_readdata = UNMAPPED_DATA;
		unique case (address_in)
			OFS_CAP_PINS:   next_readdata = capability_pins_word;
			OFS_CAP_GPIO:   next_readdata = capability_gpio_word;
			OFS_RUN_GATE:   next_readdata = run_gate_set;
			OFS_SLEEP_GATE: next_readdata = sleep_gate_set;
			OFS_DEEP_GATE:  next_readdata = deep_sleep_gate_set;
			OFS_RUN_CFG:    next_readdata = run_clock_configuration;
			OFS_PWR_STATE:  next_readdata = {29'h0, pwr_state};
			default:        next_response = RESP_ERR;
		endcase
	end

	// Data and response are caught when a request is taken and then stand
	// unchanged until the next request is taken.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			done         <= 1'b0;
			readdata_out <= 32'h0000_0000;
			response_out <= RESP_OK;
		end else begin
			done <= access & ~done;
			if (access && !done) begin
				readdata_out <= read_in ? next_readdata : 32'h0000_0000;
				response_out <= next_response;
			end
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_gate_reset_zero: assert property (
		$rose(rst_n_in) |-> run_gate_set == 32'h0 && !wdog_clk_en_out)
		else $error("gating set not zero after reset");
	a_unused_bits_zero: assert property (
		((run_gate_set | sleep_gate_set | deep_sleep_gate_set) &
		32'hffff_fff7) == 32'h0)
		else $error("unused gating bit set");
	a_cap_pins_const: assert property (
		capability_pins_word == 32'hbf00_7fc0)
		else $error("pins word wrong");
	a_cap_gpio_const: assert property (
		capability_gpio_word == 32'h0000_001f)
		else $error("gpio word wrong");
	a_wdog_fault_off: assert property (
		wdog_access_in && !wdog_clk_en_out |=> wdog_fault_out)
		else $error("missing fault on gated unit");
	a_no_fault_on: assert property (
		wdog_access_in && wdog_clk_en_out |=> !wdog_fault_out)
		else $error("fault on clocked unit");
	a_run_set_rules: assert property (
		!run_clock_configuration[AUTO_GATE_BIT] |->
		wdog_clk_en_out == run_gate_set[WDOG_BIT])
		else $error("run set not in force");
	a_sleep_set_used: assert property (
		run_clock_configuration[AUTO_GATE_BIT] && pwr_state == PWR_SLEEP
		|-> wdog_clk_en_out == sleep_gate_set[WDOG_BIT])
		else $error("sleep set not in force");
	a_wdog_write: assert property (
		write_in && !done && address_in == OFS_RUN_GATE && byteenable_in[0]
		|=> run_gate_set[WDOG_BIT] == $past(writedata_in[WDOG_BIT]))
		else $error("watchdog bit not written");
	a_bus_answer: assert property (
		access && !done |=> !waitrequest_out)
		else $error("bus answer late");

	// Which gating copy drives the enable in each power state, and that the state stays one-hot.
	a_deep_set_used: assert property (
		run_clock_configuration[AUTO_GATE_BIT] && pwr_state == PWR_DEEP
		|-> wdog_clk_en_out == deep_sleep_gate_set[WDOG_BIT])
		else $error("deep sleep set not in force");
	a_run_state_used: assert property (
		pwr_state == PWR_RUN |-> wdog_clk_en_out == run_gate_set[WDOG_BIT])
		else $error("run set not in force while running");
	a_power_one_hot: assert property (
		$onehot(pwr_state))
		else $error("power state not one-hot");

	// The fault pulse needs a cause: an access while the clock was off.
	a_fault_has_cause: assert property (
		wdog_fault_out |-> $past(wdog_access_in) && !$past(wdog_clk_en_out))
		else $error("fault without gated access");
	a_fault_quiet: assert property (
		!wdog_access_in |=> !wdog_fault_out)
		else $error("fault without access");

	// Reset values of the copies and run configuration, read-only zero bits of the run configuration, and wait-cycle hold of the gating copies.
	a_copies_reset_zero: assert property (
		$rose(rst_n_in) |-> sleep_gate_set == 32'h0 &&
		deep_sleep_gate_set == 32'h0 && run_clock_configuration == 32'h0)
		else $error("copy not zero after reset");
	a_cfg_bits_zero: assert property (
		(run_clock_configuration & ~RUN_CFG_MASK) == 32'h0)
		else $error("unused configuration bit set");
	a_gates_hold_busy: assert property (
		done |=> $stable(run_gate_set) && $stable(sleep_gate_set) &&
		$stable(deep_sleep_gate_set))
		else $error("gating copy changed in the wait cycle");

	// Bus answers for the fixed words and for unmapped offsets, and the hold of any answer between requests.
	a_pins_read_back: assert property (
		read_in && !done && address_in == OFS_CAP_PINS
		|=> readdata_out == 32'hbf00_7fc0 && response_out == RESP_OK)
		else $error("pins word read wrong");
	a_gpio_read_back: assert property (
		read_in && !done && address_in == OFS_CAP_GPIO
		|=> readdata_out == 32'h0000_001f && response_out == RESP_OK)
		else $error("gpio word read wrong");
	a_cap_write_ok: assert property (
		write_in && !done &&
		(address_in == OFS_CAP_PINS || address_in == OFS_CAP_GPIO)
		|=> response_out == RESP_OK && capability_gpio_word == 32'h1f)
		else $error("capability write not ignored");
	a_unmapped_error: assert property (
		access && !done && address_in == 10'h3fc
		|=> response_out == RESP_ERR && readdata_out == 32'h0)
		else $error("unmapped offset answered");
	a_answer_stands: assert property (
		!(access && !done) |=> $stable(readdata_out) &&
		$stable(response_out))
		else $error("bus answer moved while idle");

	// Main scenarios that the bench is expected to reach.
	c_gate_on: cover property (wdog_clk_en_out);
	c_sleep_use: cover property (pwr_state == PWR_SLEEP &&
		run_clock_configuration[AUTO_GATE_BIT]);
	c_fault: cover property (wdog_fault_out);
	c_bad_addr: cover property (!waitrequest_out && access &&
		response_out == RESP_ERR);
	c_deep_use: cover property (pwr_state == PWR_DEEP &&
		run_clock_configuration[AUTO_GATE_BIT]);
endmodule // capability_and_clock_gating_regs

/* File: test_capability_and_clock_gating_regs.sv */
`timescale 1ns/1ps
module test_capability_and_clock_gating_regs;
	import sysctl_gate_pkg::*;

	typedef struct packed {
		logic [9:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} row_t;

	logic        clk;
	logic        rst_n;
	logic [9:0]  addr;
	logic        rd;
	logic        wr;
	logic [3:0]  be;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wait_rq;
	logic [1:0]  resp;
	logic        slp;
	logic        dslp;
	logic        wd_acc;
	logic        fault;
	logic        wd_en;
	int          error_cnt;
	int          checked;
	row_t        rows [17];

	capability_and_clock_gating_regs dut_u (
		.ref_clk_in     (clk),
		.rst_n_in       (rst_n),
		.address_in     (addr),
		.read_in        (rd),
		.write_in       (wr),
		.byteenable_in  (be),
		.writedata_in   (wdata),
		.readdata_out   (rdata),
		.waitrequest_out(wait_rq),
		.response_out   (resp),
		.sleep_in       (slp),
		.deep_sleep_in  (dslp),
		.wdog_access_in (wd_acc),
		.wdog_fault_out (fault),
		.wdog_clk_en_out(wd_en)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request stands until the rising edge at which waitrequest is
	// sampled low; the answer is taken at that edge and dropped after it.
	task automatic rw(input logic [9:0] a, input logic w,
			input logic [31:0] d, input logic [31:0] e, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		addr  <= a;
		rd    <= !w;
		wr    <= w;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wait_rq !== 1'b0 && n < 50);
		chk({30'h0, resp}, {30'h0, r});
		if (!w)
			chk(rdata, e);
		if (n >= 50)
			error_cnt++;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic poke_wdog(input logic exp);
		@(posedge clk) wd_acc <= 1'b1;
		@(posedge clk) wd_acc <= 1'b0;
		@(negedge clk);
		chk(fault, exp);
		@(negedge clk);
		chk(fault, 1'b0);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		{rst_n, addr, rd, wr, wdata, slp, dslp, wd_acc} = '0;
		be = 4'hf;
		error_cnt = 0;
		checked = 0;
		rows = '{
			'{OFS_RUN_GATE, 1'b0, 32'h0, 32'h0, 2'h0},
			'{OFS_SLEEP_GATE, 1'b0, 32'h0, 32'h0, 2'h0},
			'{OFS_DEEP_GATE, 1'b0, 32'h0, 32'h0, 2'h0},
			'{OFS_RUN_CFG, 1'b0, 32'h0, 32'h0, 2'h0},
			'{OFS_CAP_PINS, 1'b0, 32'h0, 32'hbf007fc0, 2'h0},
			'{OFS_CAP_GPIO, 1'b0, 32'h0, 32'h1f, 2'h0},
			'{OFS_CAP_PINS, 1'b1, 32'h0, 32'h0, 2'h0},
			'{OFS_CAP_GPIO, 1'b1, 32'h0, 32'h0, 2'h0},
			'{OFS_CAP_PINS, 1'b0, 32'h0, 32'hbf007fc0, 2'h0},
			'{OFS_CAP_GPIO, 1'b0, 32'h0, 32'h1f, 2'h0},
			'{OFS_RUN_GATE, 1'b1, 32'hffffffff, 32'h0, 2'h0},
			'{OFS_RUN_GATE, 1'b0, 32'h0, 32'h8, 2'h0},
			'{OFS_SLEEP_GATE, 1'b1, 32'hffffffff, 32'h0, 2'h0},
			'{OFS_SLEEP_GATE, 1'b0, 32'h0, 32'h8, 2'h0},
			'{10'h3fc, 1'b1, 32'hffffffff, 32'h0, 2'h2},
			'{10'h3fc, 1'b0, 32'h0, 32'h0, 2'h2},
			'{OFS_PWR_STATE, 1'b0, 32'h0, 32'h1, 2'h0}
		};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk(wd_en, 1'b0);
		foreach (rows[i])
			rw(rows[i].a, rows[i].w, rows[i].d, rows[i].e, rows[i].r);
		// A gated-off watchdog faults on access; a clocked one does not.
		rw(OFS_RUN_GATE, 1'b1, 32'h0, 32'h0, 2'h0);
		@(negedge clk);
		chk(wd_en, 1'b0);
		poke_wdog(1'b1);
		rw(OFS_RUN_GATE, 1'b1, 32'h8, 32'h0, 2'h0);
		@(negedge clk);
		chk(wd_en, 1'b1);
		poke_wdog(1'b0);
		// Sleep sets are ignored until automatic gating is selected.
		rw(OFS_SLEEP_GATE, 1'b1, 32'h0, 32'h0, 2'h0);
		rw(OFS_DEEP_GATE, 1'b1, 32'h8, 32'h0, 2'h0);
		@(posedge clk) slp <= 1'b1;
		settle();
		chk(wd_en, 1'b1);
		rw(OFS_RUN_CFG, 1'b1, 32'hffffffff, 32'h0, 2'h0);
		settle();
		chk(wd_en, 1'b0);
		poke_wdog(1'b1);
		rw(OFS_PWR_STATE, 1'b0, 32'h0, 32'h2, 2'h0);
		@(posedge clk) dslp <= 1'b1;
		settle();
		chk(wd_en, 1'b1);
		rw(OFS_PWR_STATE, 1'b0, 32'h0, 32'h4, 2'h0);
		rw(OFS_RUN_CFG, 1'b0, 32'h0, 32'h08000000, 2'h0);
		// A second reset in mid-run clears every gating copy again.
		@(posedge clk) rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rw(OFS_DEEP_GATE, 1'b0, 32'h0, 32'h0, 2'h0);
		rw(OFS_RUN_GATE, 1'b0, 32'h0, 32'h0, 2'h0);
		rw(OFS_RUN_CFG, 1'b0, 32'h0, 32'h0, 2'h0);
		@(negedge clk);
		chk(wd_en, 1'b0);
		report_and_stop();
	end
endmodule // test_capability_and_clock_gating_regs
